// ### rtl/fgm_pkg.sv
package fgm_pkg;

  // register word offsets on the host register port
  localparam logic [7:0]  OFS_THERMAL_WORD       = 8'h08;
  localparam logic [7:0]  OFS_CELL_VOLTAGE_WORD  = 8'h09;
  localparam logic [7:0]  OFS_SENSED_CURRENT     = 8'h0a;
  localparam logic [7:0]  OFS_MEAN_CURRENT       = 8'h0b;
  localparam logic [7:0]  OFS_MEAN_CELL_VOLTAGE  = 8'h19;
  localparam logic [7:0]  OFS_VOLTAGE_PEAK       = 8'h1b;
  localparam logic [7:0]  OFS_CURRENT_PEAK       = 8'h1c;

  // power-up values
  localparam logic [15:0] VOLTAGE_PEAK_INIT      = 16'h00ff;
  localparam logic [15:0] CURRENT_PEAK_INIT      = 16'h807f;
  localparam logic [15:0] WORD_ZERO              = 16'h0000;

  // field positions inside the peak trackers
  localparam int          HIGH_FIELD_MSB         = 15;
  localparam int          HIGH_FIELD_LSB         = 8;
  localparam int          LOW_FIELD_MSB          = 7;
  localparam int          LOW_FIELD_LSB          = 0;

  // current word limits, 31.25 uA per code over +/-1.024 A
  localparam logic signed [15:0] CURRENT_POS_LIMIT = 16'sh7fff;
  localparam logic signed [15:0] CURRENT_NEG_LIMIT = -16'sh8000;

  // 160 mA peak step over 31.25 uA current code
  localparam logic signed [15:0] CURRENT_PEAK_STEP = 16'sh1400;

  // running average weight, new sample counts 1/2**AVG_SHIFT
  localparam int          AVG_SHIFT              = 3;

  // time-type word, 5.625 s per code
  localparam real         CLK_HZ                 = 50.0e6;
  localparam real         TIME_LSB_S             = 5.625;
  localparam int unsigned TIME_LSB_CYCLES        = int'(TIME_LSB_S * CLK_HZ);
  localparam logic [15:0] TIME_WORD_FULL         = 16'hffff;

endpackage : fgm_pkg

// ### rtl/fgm_peak_tracker.sv
`timescale 1ns/1ps
module fgm_peak_tracker
  import fgm_pkg::*;
#(
  parameter logic [15:0] INIT_WORD  = 16'h0000,
  parameter bit          SIGNED_CMP = 1'b0
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // sample commit
  input  wire logic        i_update,
  input  wire logic [7:0]  i_sample,
  // host write
  input  wire logic        i_wr,
  input  wire logic [15:0] i_wdata,
  // tracker word
  output logic      [15:0] o_word
);

  logic [7:0] high_reg;
  logic [7:0] low_reg;
  logic [7:0] high_next;
  logic [7:0] low_next;
  wire        rearm     = i_wr && (i_wdata == INIT_WORD);
  wire        above     = SIGNED_CMP ? ($signed(i_sample) > $signed(high_reg))
                                     : (i_sample > high_reg);
  wire        below     = SIGNED_CMP ? ($signed(i_sample) < $signed(low_reg))
                                     : (i_sample < low_reg);

  // host write wins over a sample in the same cycle
  always_comb begin
    high_next = high_reg;
    low_next  = low_reg;
    if (rearm) begin
      high_next = INIT_WORD[HIGH_FIELD_MSB:HIGH_FIELD_LSB];
      low_next  = INIT_WORD[LOW_FIELD_MSB:LOW_FIELD_LSB];
    end else if (i_wr) begin
      high_next = i_wdata[HIGH_FIELD_MSB:HIGH_FIELD_LSB];
      low_next  = i_wdata[LOW_FIELD_MSB:LOW_FIELD_LSB];
    end else if (i_update) begin
      if (above) begin
        high_next = i_sample;
      end
      if (below) begin
        low_next = i_sample;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      high_reg <= INIT_WORD[HIGH_FIELD_MSB:HIGH_FIELD_LSB];
      low_reg  <= INIT_WORD[LOW_FIELD_MSB:LOW_FIELD_LSB];
    end else begin
      high_reg <= high_next;
      low_reg  <= low_next;
    end
  end

  assign o_word = {high_reg, low_reg};

endmodule : fgm_peak_tracker

// ### rtl/fgm_meas_regs.sv
// What this block does
// - words keep their type format; elapsed word counts 5.625 s per code
// - percentage words read in whole percent from their upper byte alone
// - temperature words are signed, upper byte gives whole degrees
// - cell voltage word holds the battery sense pin voltage sample
// - mean cell voltage word is a running average of voltage samples
// - voltage tracker: highest in upper byte, lowest in lower, 20 mV steps
// - voltage tracker powers up as 0x00ff
// - each voltage sample raises highest or lowers lowest field as needed, unless a host tracker write lands in the same cycle
// - host write of 0x00ff re-arms the voltage tracker
// - sensed current word is signed, 31.25 uA per code
// - out-of-range current saturates at full scale, never wraps
// - mean current word is a running average of current samples
// - current tracker holds signed highest and lowest, 160 mA steps
// - current tracker powers up as 0x807f
// - host write of 0x807f re-arms the current tracker
// - thermal word follows thermistor or die per source select
// - source select low puts die temperature into thermal word
`timescale 1ns/1ps
module fgm_meas_regs
  import fgm_pkg::*;
#(
  parameter int unsigned ELAPSED_TICK_CYCLES = TIME_LSB_CYCLES
) (
  // clock and reset
  input  wire logic               I_CLK,
  input  wire logic               I_NRST,

  // voltage front end
  input  wire logic               I_VOLT_VALID,
  input  wire logic        [15:0] I_VOLT_SAMPLE,

  // current front end
  input  wire logic               I_CUR_VALID,
  input  wire logic signed [19:0] I_CUR_RAW,

  // temperature front end
  input  wire logic               I_DIE_VALID,
  input  wire logic        [15:0] I_DIE_THERMAL_WORD,
  input  wire logic               I_THERM_VALID,
  input  wire logic        [15:0] I_THERM_SAMPLE,
  input  wire logic               I_THERMAL_SOURCE_SELECT,

  // percentage word from the gauge core
  input  wire logic        [15:0] I_PERCENT_WORD,

  // host register port
  input  wire logic        [7:0]  I_REG_ADDR,
  input  wire logic               I_REG_WR,
  input  wire logic               I_REG_RD,
  input  wire logic        [15:0] I_REG_WDATA,
  output logic             [15:0] O_REG_RDATA,
  output logic                    O_REG_ACK,
  output logic                    O_REG_HIT,

  // whole-unit views and elapsed time word
  output logic             [7:0]  O_THERMAL_WHOLE_DEG,
  output logic             [7:0]  O_PERCENT_WHOLE,
  output logic             [15:0] O_ELAPSED_WORD
);

  // saturate a wide current code into the 16-bit word
  function automatic logic [15:0] sat_current(input logic signed [19:0] raw);
    logic [15:0] res;
    res = raw[15:0];
    if (raw > 20'(CURRENT_POS_LIMIT)) begin
      res = CURRENT_POS_LIMIT;
    end else if (raw < 20'(CURRENT_NEG_LIMIT)) begin
      res = CURRENT_NEG_LIMIT;
    end
    return res;
  endfunction : sat_current

  // one step of the running average, 17-bit signed math
  function automatic logic [15:0] avg_step(input logic signed [16:0] avg,
                                           input logic signed [16:0] smp);
    logic signed [16:0] diff;
    logic signed [16:0] sum;
    diff = smp - avg;
    sum  = avg + (diff >>> AVG_SHIFT);
    return sum[15:0];
  endfunction : avg_step

  // integer part of a 1/256-unit word
  function automatic logic [7:0] whole_part(input logic [15:0] w);
    return w[HIGH_FIELD_MSB:HIGH_FIELD_LSB];
  endfunction : whole_part

  // current code to 160 mA steps, truncated toward zero
  function automatic logic [7:0] current_to_peak(input logic signed [15:0] w);
    logic signed [15:0] q;
    q = w / CURRENT_PEAK_STEP;
    return q[7:0];
  endfunction : current_to_peak

  // measurement words
  logic [15:0] cell_voltage_word_reg;
  logic [15:0] cell_voltage_word_next;
  logic [15:0] mean_cell_voltage_word_reg;
  logic [15:0] mean_cell_voltage_word_next;
  logic        volt_seen_reg;
  logic [15:0] sensed_current_word_reg;
  logic [15:0] sensed_current_word_next;
  logic [15:0] mean_current_word_reg;
  logic [15:0] mean_current_word_next;
  logic        cur_seen_reg;
  logic [15:0] thermal_word_reg;
  logic [15:0] thermal_word_next;

  // elapsed timer
  logic [31:0] tick_cnt_reg;
  logic [31:0] tick_cnt_next;
  logic [15:0] elapsed_reg;
  logic [15:0] elapsed_next;

  // register read path
  logic [15:0] rdata_reg;
  logic        ack_reg;
  logic [7:0]  pct_whole_reg;
  logic [15:0] voltage_peak_tracker;
  logic [15:0] current_peak_tracker;

  // saturated current for this cycle
  wire  [15:0] cur_sat = sat_current(I_CUR_RAW);

  // thermal source choice
  wire         thermal_commit;
  wire  [15:0] thermal_sample;

  // register decode
  wire         sel_thermal  = (I_REG_ADDR == OFS_THERMAL_WORD);
  wire         sel_cell     = (I_REG_ADDR == OFS_CELL_VOLTAGE_WORD);
  wire         sel_current  = (I_REG_ADDR == OFS_SENSED_CURRENT);
  wire         sel_mean_cur = (I_REG_ADDR == OFS_MEAN_CURRENT);
  wire         sel_mean_vlt = (I_REG_ADDR == OFS_MEAN_CELL_VOLTAGE);
  wire         sel_vpeak    = (I_REG_ADDR == OFS_VOLTAGE_PEAK);
  wire         sel_cpeak    = (I_REG_ADDR == OFS_CURRENT_PEAK);
  wire         addr_hit     = sel_thermal | sel_cell | sel_current | sel_mean_cur
                            | sel_mean_vlt | sel_vpeak | sel_cpeak;
  wire         wr_vpeak     = I_REG_WR && sel_vpeak;
  wire         wr_cpeak     = I_REG_WR && sel_cpeak;

  // tracker inputs, converted by truncation
  wire  [7:0]  volt_peak_sample;
  wire  [7:0]  cur_peak_sample;

  // read mux, unmapped addresses read zero
  wire  [15:0] rd_mux;

  assign cell_voltage_word_next = I_VOLT_VALID ? I_VOLT_SAMPLE : cell_voltage_word_reg;

  assign mean_cell_voltage_word_next =
    !I_VOLT_VALID  ? mean_cell_voltage_word_reg :
    !volt_seen_reg ? I_VOLT_SAMPLE :
    avg_step({1'b0, mean_cell_voltage_word_reg}, {1'b0, I_VOLT_SAMPLE});

  assign sensed_current_word_next = I_CUR_VALID ? cur_sat : sensed_current_word_reg;

  assign mean_current_word_next =
    !I_CUR_VALID  ? mean_current_word_reg :
    !cur_seen_reg ? cur_sat :
    avg_step({mean_current_word_reg[15], mean_current_word_reg},
             {cur_sat[15], cur_sat});

  assign thermal_commit = I_THERMAL_SOURCE_SELECT ? I_THERM_VALID : I_DIE_VALID;
  assign thermal_sample = I_THERMAL_SOURCE_SELECT ? I_THERM_SAMPLE : I_DIE_THERMAL_WORD;
  assign thermal_word_next = thermal_commit ? thermal_sample : thermal_word_reg;

  assign tick_cnt_next = (tick_cnt_reg == 32'(ELAPSED_TICK_CYCLES - 1)) ? 32'h0000_0000
                                                                       : tick_cnt_reg + 32'h1;
  assign elapsed_next  = ((tick_cnt_reg == 32'(ELAPSED_TICK_CYCLES - 1))
                         && (elapsed_reg != TIME_WORD_FULL)) ? elapsed_reg + 16'h0001
                                                             : elapsed_reg;

  assign volt_peak_sample = whole_part(I_VOLT_SAMPLE);

  assign cur_peak_sample = current_to_peak(cur_sat);

  assign rd_mux =
    sel_thermal  ? thermal_word_reg :
    sel_cell     ? cell_voltage_word_reg :
    sel_current  ? sensed_current_word_reg :
    sel_mean_cur ? mean_current_word_reg :
    sel_mean_vlt ? mean_cell_voltage_word_reg :
    sel_vpeak    ? voltage_peak_tracker :
    sel_cpeak    ? current_peak_tracker :
    WORD_ZERO;

  // measurement word storage
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      cell_voltage_word_reg <= WORD_ZERO;
    end else begin
      cell_voltage_word_reg <= cell_voltage_word_next;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      mean_cell_voltage_word_reg <= WORD_ZERO;
    end else begin
      mean_cell_voltage_word_reg <= mean_cell_voltage_word_next;
    end
  end

  // first sample loads the average, no slow ramp up from zero
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      volt_seen_reg <= 1'b0;
    end else begin
      volt_seen_reg <= volt_seen_reg | I_VOLT_VALID;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      sensed_current_word_reg <= WORD_ZERO;
    end else begin
      sensed_current_word_reg <= sensed_current_word_next;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      mean_current_word_reg <= WORD_ZERO;
    end else begin
      mean_current_word_reg <= mean_current_word_next;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      cur_seen_reg <= 1'b0;
    end else begin
      cur_seen_reg <= cur_seen_reg | I_CUR_VALID;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      thermal_word_reg <= WORD_ZERO;
    end else begin
      thermal_word_reg <= thermal_word_next;
    end
  end

  // free-running, starts after reset release
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      elapsed_reg <= WORD_ZERO;
    end else begin
      elapsed_reg <= elapsed_next;
    end
  end

  // read data registered so the port sees a stable word
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      rdata_reg <= WORD_ZERO;
    end else begin
      rdata_reg <= I_REG_RD ? rd_mux : rdata_reg;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= I_REG_RD;
    end
  end

  // percent byte from a flop, one cycle behind the core word
  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      pct_whole_reg <= whole_part(WORD_ZERO);
    end else begin
      pct_whole_reg <= whole_part(I_PERCENT_WORD);
    end
  end

  fgm_peak_tracker #(
    .INIT_WORD  (VOLTAGE_PEAK_INIT),
    .SIGNED_CMP (1'b0)
  ) u_voltage_peak (
    .i_clk    (I_CLK),
    .i_nrst   (I_NRST),
    .i_update (I_VOLT_VALID),
    .i_sample (volt_peak_sample),
    .i_wr     (wr_vpeak),
    .i_wdata  (I_REG_WDATA),
    .o_word   (voltage_peak_tracker)
  );

  fgm_peak_tracker #(
    .INIT_WORD  (CURRENT_PEAK_INIT),
    .SIGNED_CMP (1'b1)
  ) u_current_peak (
    .i_clk    (I_CLK),
    .i_nrst   (I_NRST),
    .i_update (I_CUR_VALID),
    .i_sample (cur_peak_sample),
    .i_wr     (wr_cpeak),
    .i_wdata  (I_REG_WDATA),
    .o_word   (current_peak_tracker)
  );

  // outputs
  assign O_REG_RDATA         = rdata_reg;
  assign O_REG_ACK           = ack_reg;
  assign O_REG_HIT           = addr_hit;

  assign O_THERMAL_WHOLE_DEG = whole_part(thermal_word_reg);

  assign O_PERCENT_WHOLE     = pct_whole_reg;

  assign O_ELAPSED_WORD      = elapsed_reg;

endmodule : fgm_meas_regs

// ### tb/fgm_meas_regs_properties.sv
`timescale 1ns/1ps
module fgm_meas_regs_properties
  import fgm_pkg::*;
#(
  parameter int unsigned ELAPSED_TICK_CYCLES = TIME_LSB_CYCLES
) (
  input wire logic               I_CLK,
  input wire logic               I_NRST,
  input wire logic               I_VOLT_VALID,
  input wire logic        [15:0] I_VOLT_SAMPLE,
  input wire logic               I_CUR_VALID,
  input wire logic signed [19:0] I_CUR_RAW,
  input wire logic               I_DIE_VALID,
  input wire logic        [15:0] I_DIE_THERMAL_WORD,
  input wire logic               I_THERM_VALID,
  input wire logic        [15:0] I_THERM_SAMPLE,
  input wire logic               I_THERMAL_SOURCE_SELECT,
  input wire logic        [15:0] I_PERCENT_WORD,
  input wire logic        [7:0]  I_REG_ADDR,
  input wire logic               I_REG_WR,
  input wire logic               I_REG_RD,
  input wire logic        [15:0] I_REG_WDATA,
  input wire logic        [15:0] O_REG_RDATA,
  input wire logic        [7:0]  O_THERMAL_WHOLE_DEG,
  input wire logic        [7:0]  O_PERCENT_WHOLE,
  input wire logic        [15:0] O_ELAPSED_WORD
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);

  logic        [15:0] last_reg;
  int unsigned        since_reg;
  wire logic          rd_only = I_REG_RD && !I_REG_WR;
  wire logic          v_init  = I_REG_WR && I_REG_ADDR == OFS_VOLTAGE_PEAK
                                && I_REG_WDATA == VOLTAGE_PEAK_INIT;
  wire logic          c_init  = I_REG_WR && I_REG_ADDR == OFS_CURRENT_PEAK
                                && I_REG_WDATA == CURRENT_PEAK_INIT;
  wire logic          c_over  = I_CUR_VALID
                                && (I_CUR_RAW > 20'sh07fff || I_CUR_RAW < -20'sh08000);

  // cycles since the elapsed word last moved, a stuck counter shows here
  always_ff @(posedge I_CLK) begin
    last_reg  <= O_ELAPSED_WORD;
    since_reg <= (!I_NRST || O_ELAPSED_WORD != last_reg) ? 0 : since_reg + 1;
  end

  AST_ELAPSED_TICK: assert property (
    O_ELAPSED_WORD != TIME_WORD_FULL |-> since_reg <= ELAPSED_TICK_CYCLES) else $error("tick");
  AST_PCT_WHOLE: assert property ($past(I_NRST) |->
    O_PERCENT_WHOLE == $past(I_PERCENT_WORD[15:8])) else $error("percent byte");
  AST_CELL_READ: assert property (I_VOLT_VALID ##1
    (rd_only && I_REG_ADDR == OFS_CELL_VOLTAGE_WORD) |=> O_REG_RDATA == $past(I_VOLT_SAMPLE, 2))
    else $error("cell word");
  AST_VPEAK_FIRST: assert property (v_init ##1 (I_VOLT_VALID && !I_REG_WR)
    ##1 (rd_only && I_REG_ADDR == OFS_VOLTAGE_PEAK) |=> O_REG_RDATA[15:8] == O_REG_RDATA[7:0]
    && {O_REG_RDATA[15:8], 8'h00} == ($past(I_VOLT_SAMPLE, 2) & 16'hff00))
    else $error("voltage first update");
  AST_VPEAK_REARM: assert property (v_init ##1
    (rd_only && I_REG_ADDR == OFS_VOLTAGE_PEAK) |=> O_REG_RDATA == VOLTAGE_PEAK_INIT)
    else $error("voltage rearm");
  AST_CPEAK_REARM: assert property (c_init ##1
    (rd_only && I_REG_ADDR == OFS_CURRENT_PEAK) |=> O_REG_RDATA == CURRENT_PEAK_INIT)
    else $error("current rearm");
  AST_CUR_SAT: assert property (c_over ##1
    (rd_only && I_REG_ADDR == OFS_SENSED_CURRENT)
    |=> O_REG_RDATA == ($past(I_CUR_RAW, 2) < 0 ? 16'h8000 : 16'h7fff)) else $error("saturation");
  AST_THERM_SRC: assert property (I_THERM_VALID && I_THERMAL_SOURCE_SELECT
    |=> {O_THERMAL_WHOLE_DEG, 8'h00} == ($past(I_THERM_SAMPLE) & 16'hff00))
    else $error("thermistor source");
  AST_DIE_SRC: assert property (I_DIE_VALID && !I_THERMAL_SOURCE_SELECT
    |=> {O_THERMAL_WHOLE_DEG, 8'h00} == ($past(I_DIE_THERMAL_WORD) & 16'hff00))
    else $error("die source");

  COV_REARM_RACE: cover property (v_init && I_VOLT_VALID);
  COV_CUR_SAT: cover property (c_over && I_CUR_RAW < 0);
  COV_THERM: cover property (I_THERM_VALID && I_THERMAL_SOURCE_SELECT);
endmodule : fgm_meas_regs_properties

// ### tb/fgm_meas_regs_bench.sv
`timescale 1ns/1ps
module fgm_meas_regs_bench;
  import fgm_pkg::*;

  localparam int unsigned TICK = 4;
  localparam logic [5:0]  RD   = 6'h20;
  localparam logic [5:0]  WR   = 6'h10;
  localparam logic [5:0]  VV   = 6'h08;
  localparam logic [5:0]  CV   = 6'h04;
  localparam logic [5:0]  DV   = 6'h02;
  localparam logic [5:0]  TV   = 6'h01;

  logic               clk, nrst, rd, wr, vv, cv, dv, tv, sel, ack, hit;
  logic        [15:0] vs, dw, tw, pw, wdata, rdata, el, e, v_avg, c_avg, th;
  logic signed [19:0] cr;
  logic        [7:0]  addr, deg, pct;
  logic        [7:0]  vh = 8'h00, vl = 8'hff;
  logic signed [7:0]  ch = 8'sh80, cl = 8'sh7f;
  bit                 v_first = 1'b1, c_first = 1'b1;
  int                 failures, checked;
  int                 seed = 73;
  logic        [7:0]  ofs [8] = '{OFS_THERMAL_WORD, OFS_CELL_VOLTAGE_WORD, OFS_SENSED_CURRENT,
    OFS_MEAN_CURRENT, OFS_MEAN_CELL_VOLTAGE, OFS_VOLTAGE_PEAK, OFS_CURRENT_PEAK, 8'h1d};
  logic signed [19:0] corner [6] = '{20'sh07fff, 20'sh08000, -20'sh08000, -20'sh08001,
    20'sh7ffff, 20'sh80000};

  fgm_meas_regs #(.ELAPSED_TICK_CYCLES(TICK)) i_dut (
    .I_CLK(clk), .I_NRST(nrst), .I_VOLT_VALID(vv), .I_VOLT_SAMPLE(vs), .I_CUR_VALID(cv),
    .I_CUR_RAW(cr), .I_DIE_VALID(dv), .I_DIE_THERMAL_WORD(dw), .I_THERM_VALID(tv),
    .I_THERM_SAMPLE(tw), .I_THERMAL_SOURCE_SELECT(sel), .I_PERCENT_WORD(pw),
    .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata),
    .O_REG_RDATA(rdata), .O_REG_ACK(ack), .O_REG_HIT(hit), .O_THERMAL_WHOLE_DEG(deg),
    .O_PERCENT_WHOLE(pct), .O_ELAPSED_WORD(el)
  );

  always #10 clk = ~clk;

  function automatic logic [15:0] avg_next(logic [15:0] avg, logic [15:0] s, bit sg);
    logic signed [16:0] d;
    d = signed'({sg & s[15], s}) - signed'({sg & avg[15], avg});
    return avg + 16'(d >>> 3);
  endfunction : avg_next

  function automatic logic [15:0] sat(logic signed [19:0] r);
    return r > 20'sh07fff ? 16'h7fff : r < -20'sh08000 ? 16'h8000 : r[15:0];
  endfunction : sat

  function automatic logic mapped(logic [7:0] a);
    return a inside {OFS_THERMAL_WORD, OFS_CELL_VOLTAGE_WORD, OFS_SENSED_CURRENT,
      OFS_MEAN_CURRENT, OFS_MEAN_CELL_VOLTAGE, OFS_VOLTAGE_PEAK, OFS_CURRENT_PEAK};
  endfunction : mapped

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // every strobe set once per cycle, so back-to-back calls never clash
  task automatic cyc(logic [5:0] s, logic [7:0] a = 8'h00, logic [15:0] w = 16'h0000);
    {rd, wr, vv, cv, dv, tv} = s;
    addr = a;
    wdata = w;
    pw = 16'($random(seed));
    tick;
  endtask : cyc

  task automatic rd_chk(string n, logic [7:0] a, logic [15:0] exp);
    cyc(RD, a);
    chk(n, rdata, exp);
    chk("ack", {15'h0000, ack}, 16'h0001);
    chk("hit", {15'h0000, hit}, {15'h0000, mapped(a)});
  endtask : rd_chk

  task automatic vmodel(logic [15:0] s);
    v_avg = v_first ? s : avg_next(v_avg, s, 1'b0);
    v_first = 1'b0;
    if (s[15:8] > vh) vh = s[15:8];
    if (s[15:8] < vl) vl = s[15:8];
  endtask : vmodel

  task automatic cmodel(logic signed [19:0] r);
    logic signed [15:0] w;
    logic signed [7:0]  q;
    w = sat(r);
    q = 8'(w / CURRENT_PEAK_STEP);
    c_avg = c_first ? w : avg_next(c_avg, w, 1'b1);
    c_first = 1'b0;
    if (q > ch) ch = q;
    if (q < cl) cl = q;
  endtask : cmodel

  task automatic give_verdict;
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    {clk, nrst, rd, wr, vv, cv, dv, tv, sel} = '0;
    {vs, dw, tw, pw, wdata, addr, cr} = '0;
    th = WORD_ZERO;
    repeat (6) tick;
    nrst = 1'b1;
    foreach (ofs[i]) rd_chk("reset", ofs[i], ofs[i] == OFS_VOLTAGE_PEAK ? VOLTAGE_PEAK_INIT :
      ofs[i] == OFS_CURRENT_PEAK ? CURRENT_PEAK_INIT : WORD_ZERO);
    for (int i = 0; i < 16; i++) begin
      vs = i == 0 ? 16'h0000 : i == 1 ? 16'hffff : 16'($random(seed));
      cyc(VV);
      vmodel(vs);
      rd_chk("cell", OFS_CELL_VOLTAGE_WORD, vs);
      rd_chk("mean cell", OFS_MEAN_CELL_VOLTAGE, v_avg);
      rd_chk("volt peak", OFS_VOLTAGE_PEAK, {vh, vl});
    end
    cyc(WR, OFS_CELL_VOLTAGE_WORD, ~vs);
    rd_chk("cell ro", OFS_CELL_VOLTAGE_WORD, vs);
    cyc(WR, OFS_VOLTAGE_PEAK, 16'h1234);
    {vh, vl} = 16'h1234;
    rd_chk("volt rw", OFS_VOLTAGE_PEAK, {vh, vl});
    vs = 16'h9a00;
    cyc(WR | VV, OFS_VOLTAGE_PEAK, VOLTAGE_PEAK_INIT);
    vmodel(vs);
    {vh, vl} = VOLTAGE_PEAK_INIT;
    rd_chk("volt rearm", OFS_VOLTAGE_PEAK, VOLTAGE_PEAK_INIT);
    cyc(WR, OFS_VOLTAGE_PEAK, VOLTAGE_PEAK_INIT);
    vs = 16'h4321;
    cyc(VV);
    vmodel(vs);
    rd_chk("volt first", OFS_VOLTAGE_PEAK, {vh, vl});
    rd_chk("mean cell", OFS_MEAN_CELL_VOLTAGE, v_avg);
    for (int i = 0; i < 16; i++) begin
      cr = i < 6 ? corner[i] : 20'(17'($random(seed)));
      cyc(CV);
      cmodel(cr);
      rd_chk("current", OFS_SENSED_CURRENT, sat(cr));
      rd_chk("mean current", OFS_MEAN_CURRENT, c_avg);
      rd_chk("cur peak", OFS_CURRENT_PEAK, {ch, cl});
    end
    cr = -20'sh01800;
    cyc(WR | CV, OFS_CURRENT_PEAK, CURRENT_PEAK_INIT);
    cmodel(cr);
    {ch, cl} = CURRENT_PEAK_INIT;
    rd_chk("cur rearm", OFS_CURRENT_PEAK, CURRENT_PEAK_INIT);
    cr = 20'sh03000;
    cyc(CV);
    cmodel(cr);
    rd_chk("cur first", OFS_CURRENT_PEAK, {ch, cl});
    for (int i = 0; i < 8; i++) begin
      sel = i[1];
      dw = 16'($random(seed));
      tw = 16'($random(seed));
      cyc(i[0] ? TV : DV);
      if (i[0] == sel) th = i[0] ? tw : dw;
      chk("deg", {8'h00, deg}, {8'h00, th[15:8]});
      chk("pct", {8'h00, pct}, {8'h00, pw[15:8]});
      rd_chk("thermal", OFS_THERMAL_WORD, th);
    end
    cyc(6'h00);
    chk("ack idle", {15'h0000, ack}, 16'h0000);
    e = el;
    repeat (10 * TICK) tick;
    chk("elapsed", el - e, 16'h000a);
    give_verdict;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    give_verdict;
  end
endmodule : fgm_meas_regs_bench

bind fgm_meas_regs fgm_meas_regs_properties #(.ELAPSED_TICK_CYCLES(ELAPSED_TICK_CYCLES)) i_props (
  .I_CLK, .I_NRST, .I_VOLT_VALID, .I_VOLT_SAMPLE, .I_CUR_VALID, .I_CUR_RAW, .I_DIE_VALID,
  .I_DIE_THERMAL_WORD, .I_THERM_VALID, .I_THERM_SAMPLE, .I_THERMAL_SOURCE_SELECT,
  .I_PERCENT_WORD, .I_REG_ADDR, .I_REG_WR, .I_REG_RD, .I_REG_WDATA, .O_REG_RDATA,
  .O_THERMAL_WHOLE_DEG, .O_PERCENT_WHOLE, .O_ELAPSED_WORD
);
